// [verilog/nfs_host.sv]
// host controller issuing flash write-command sequences on demand.
// assumes the flash pins sit outside the clock domain; ready/busy is synchronised here.
// Contract
// (R1) buffered program opens with aa at 555 then 55 at 2aa
// (R2) third cycle writes buffer-load code 0025h into the target sector
// (R3) fourth cycle writes word count minus one to the sector address
// (R4) first data pair after the count fixes start and buffer line
// (R5) later pairs stay in that line, in ascending sequential order
// (R6) confirm 0029h at sector address right after last word
// (R7) flash ignores address bits below the sector boundary in commands
// (R8) flash stops programming within suspend latency on suspend
// (R9) suspend codes b0h and 51h accepted during programming
// (R10) resume codes 30h and 50h; dedicated pair used for programming
// (R11) program suspend allowed while erase already suspended
// (R12) while suspended only reads, status, exit and resume are accepted
// (R13) repeated resumes ignored; suspend accepted again after resume
// (R14) host leaves at least the resume-to-suspend gap before suspending again
// (R15) no suspend or resume while an overlay space is entered
// (R16) blank check writes 33h at word 555h in the sector when idle
// (R17) host issues no blank check while busy or suspended
// (R18) blank check shows busy in bit 7, result in bit 5
// (R19) erases use six cycles; ready/busy falls at sixth write edge
// (R20) erase preprograms, verifies and leaves words at ffffh
// (R21) chip erase ignores all commands except status read
// (R22) sector erase accepts only status read and erase suspend
// (R23) chip erase skips locked sectors without failure flags
// (R24) word count beyond 256 words aborts the buffered program
// (R25) abort sets program-fail bit 4 and buffer-abort bit 3
// (R26) erase setup and final codes are parameters
module nfs_host #(
   parameter int          ADDR_W         = 26,
   parameter int          SECT_LSB       = 16,
   parameter int          LINE_LSB       = 8,
   parameter logic [15:0] ERASE_SETUP    = 16'h0080,
   parameter logic [15:0] CHIP_ERASE_CMD = 16'h0010,
   parameter logic [15:0] SECT_ERASE_CMD = 16'h0030,
   parameter int          GAP_CYC        = nfs_pkg::RES_SUSP_GAP_CYC
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              cmd_valid,
   input  wire nfs_pkg::nfs_op_t  cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [8:0]        cmd_words,
   output logic                   cmd_ready,
   input  wire logic              wr_valid,
   input  wire logic [15:0]       wr_data,
   output logic                   wr_ready,
   output logic                   cmd_done,
   output logic                   cmd_refused,
   output logic                   flash_busy,
   output logic                   prog_suspended,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [15:0]            flash_dq_out,
   output logic                   flash_dq_oe,
   output logic                   flash_ce_n,
   output logic                   flash_we_n,
   output logic                   flash_oe_n,
   input  wire logic              ready_busy_n
);
   // the line is fixed at 256 words; the gap counter is 24 bits wide
   if (LINE_LSB != 8 || SECT_LSB <= LINE_LSB || SECT_LSB >= ADDR_W ||
       GAP_CYC < 0 || GAP_CYC >= (1 << 24)) begin : g_bad_split
      $error("nfs_host: bad address split or gap");
   end

   localparam int SEQ_MAX = 6;

   typedef struct packed {
      nfs_pkg::nfs_state_t st;
      nfs_pkg::nfs_op_t    op;
      logic [2:0]          step;
      logic [2:0]          nsteps;
      logic [ADDR_W-1:0]   base;
      logic [8:0]          left;
      logic [ADDR_W-1:0]   addr;
      logic [15:0]         data;
      logic [7:0]          tcnt;
      logic [23:0]         gap;
      logic                susp;
      logic [1:0]          rb_sync;
      logic                bus_rdy;
      logic                wrdy;
      logic                done;
      logic                refused;
      logic                busy;
      nfs_pkg::nfs_bus_t   bus;
   } nfs_state_all_t;

   nfs_state_all_t s_q, s_d;

   function automatic logic [ADDR_W-1:0] cmd_word(input logic [ADDR_W-1:0] sect,
                                                  input logic [11:0] off);
      // sector bits kept, offset below the sector chosen freely  (see R7)
      cmd_word = {sect[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}} |
                 ADDR_W'(off);
   endfunction : cmd_word

   function automatic logic [ADDR_W+15:0] seq_cycle(input nfs_pkg::nfs_op_t op,
                                                     input logic [2:0] i,
                                                     input logic [ADDR_W-1:0] a,
                                                     input logic [8:0] n);
      logic [ADDR_W-1:0] adr;
      logic [15:0]       dat;
      adr = cmd_word(a, 12'h0000);
      dat = 16'h0000;
      case (i)
         3'd0, 3'd3: begin
            adr = cmd_word(a, nfs_pkg::UNLOCK1_ADDR); // see R1
            dat = nfs_pkg::UNLOCK1_DATA;
         end
         3'd1, 3'd4: begin
            adr = cmd_word(a, nfs_pkg::UNLOCK2_ADDR); // see R1
            dat = nfs_pkg::UNLOCK2_DATA;
         end
         3'd2: begin
            if (op == nfs_pkg::OP_BUF_PROG) dat = nfs_pkg::CMD_BUF_LOAD; // see R2
            else dat = ERASE_SETUP;                                       // see R26
         end
         default: begin
            if (op == nfs_pkg::OP_CHIP_ER) dat = CHIP_ERASE_CMD;          // see R19
            else dat = SECT_ERASE_CMD;                                     // see R19
         end
      endcase
      if (op == nfs_pkg::OP_BUF_PROG && i == 3'd3) begin
         adr = cmd_word(a, 12'h0000);
         dat = 16'(n - 9'd1);                                             // see R3
      end
      seq_cycle = {adr, dat};
   endfunction : seq_cycle

   always_comb begin
      logic [ADDR_W+15:0] cyc;
      logic               ok;
      cyc = '0;
      ok  = 1'b0;
      s_d = s_q;
      s_d.done    = 1'b0;
      s_d.refused = 1'b0;
      s_d.wrdy    = 1'b0;
      s_d.rb_sync = {s_q.rb_sync[0], ready_busy_n};
      s_d.busy    = ~s_q.rb_sync[1];
      if (s_q.gap != 24'd0) s_d.gap = s_q.gap - 24'd1;
      case (s_q.st)
         nfs_pkg::ST_IDLE: begin
            s_d.bus_rdy = 1'b1;
            if (cmd_valid && s_q.bus_rdy) begin
               s_d.bus_rdy = 1'b0;
               s_d.op   = cmd_op;
               s_d.base = cmd_addr;
               s_d.left = cmd_words;
               s_d.step = 3'd0;
               case (cmd_op)
                  nfs_pkg::OP_BUF_PROG: begin
                     // count 0 or above the buffer would abort the flash  (see R24)
                     ok = !s_q.susp && !s_d.busy && cmd_words != 9'd0 &&
                          cmd_words <= 9'(nfs_pkg::BUF_WORDS) &&
                          ({1'b0, cmd_addr[LINE_LSB-1:0]} + cmd_words) <= 9'h100;
                     s_d.nsteps = 3'd4;
                  end
                  nfs_pkg::OP_SUSPEND: begin
                     ok = s_d.busy && !s_q.susp && s_q.gap == 24'd0;      // see R14
                     s_d.nsteps = 3'd1;
                  end
                  nfs_pkg::OP_RESUME: begin
                     ok = s_q.susp;                                        // see R13
                     s_d.nsteps = 3'd1;
                  end
                  nfs_pkg::OP_BLANK: begin
                     ok = !s_d.busy && !s_q.susp;                          // see R17
                     s_d.nsteps = 3'd1;
                  end
                  default: begin
                     ok = !s_d.busy && !s_q.susp;
                     s_d.nsteps = 3'(SEQ_MAX);
                  end
               endcase
               if (ok) s_d.st = nfs_pkg::ST_SETUP;
               else begin
                  s_d.refused = 1'b1;
                  s_d.bus_rdy = 1'b1;
               end
            end
         end
         nfs_pkg::ST_SETUP: begin
            case (s_q.op)
               nfs_pkg::OP_SUSPEND: cyc = {s_q.base, nfs_pkg::CMD_SUSP_PROG};    // see R9
               nfs_pkg::OP_RESUME:  cyc = {s_q.base, nfs_pkg::CMD_RES_PROG};     // see R10
               nfs_pkg::OP_BLANK:
                  cyc = {cmd_word(s_q.base, nfs_pkg::BLANK_ADDR), nfs_pkg::CMD_BLANK}; // see R16
               default: cyc = seq_cycle(s_q.op, s_q.step, s_q.base, s_q.left);
            endcase
            s_d.addr = cyc[ADDR_W+15:16];
            s_d.data = cyc[15:0];
            s_d.st   = nfs_pkg::ST_WLOW;
            s_d.tcnt = 8'(nfs_pkg::WE_LOW_CYC);
         end
         nfs_pkg::ST_WLOW: begin
            s_d.bus.ce_n = 1'b0;
            s_d.bus.we_n = 1'b0;
            s_d.bus.dq_oe = 1'b1;
            s_d.bus.dq_out = s_q.data;
            if (s_q.tcnt == 8'd0) begin
               s_d.bus.we_n = 1'b1;
               s_d.st   = nfs_pkg::ST_WHIGH;
               s_d.tcnt = 8'(nfs_pkg::WE_HIGH_CYC);
            end else s_d.tcnt = s_q.tcnt - 8'd1;
         end
         nfs_pkg::ST_WHIGH: begin
            s_d.bus.ce_n  = 1'b1;
            s_d.bus.dq_oe = 1'b0;
            if (s_q.tcnt != 8'd0) s_d.tcnt = s_q.tcnt - 8'd1;
            else if (s_q.step + 3'd1 < s_q.nsteps) begin
               s_d.step = s_q.step + 3'd1;
               s_d.st   = nfs_pkg::ST_SETUP;
            end else if (s_q.op == nfs_pkg::OP_BUF_PROG) begin
               // back to data after every word; an empty count sends the confirm
               s_d.st   = nfs_pkg::ST_DATA;
               s_d.wrdy = (s_q.left != 9'd0);
            end else s_d.st = nfs_pkg::ST_DONE;
         end
         nfs_pkg::ST_DATA: begin
            if (s_q.left == 9'd0) begin
               // confirm straight after the last counted word  (see R6)
               s_d.wrdy = 1'b0;
               s_d.addr = cmd_word(s_q.addr, 12'h0000);
               s_d.data = nfs_pkg::CMD_BUF_CONFIRM;
               s_d.st   = nfs_pkg::ST_WLOW;
               s_d.tcnt = 8'(nfs_pkg::WE_LOW_CYC);
               s_d.op   = nfs_pkg::OP_CHIP_ER;
            end else begin
               s_d.wrdy = 1'b1;
               if (wr_valid && s_q.wrdy) begin
                  s_d.wrdy = 1'b0;
                  // first pair at start address, later ones ascending in line  (see R4)
                  s_d.addr = s_q.base;
                  s_d.base = s_q.base + ADDR_W'(1);                       // see R5
                  s_d.data = wr_data;
                  s_d.left = s_q.left - 9'd1;
                  s_d.st   = nfs_pkg::ST_WLOW;
                  s_d.tcnt = 8'(nfs_pkg::WE_LOW_CYC);
                  if (s_q.left == 9'd1) s_d.step = 3'd4;
               end
            end
         end
         nfs_pkg::ST_DONE: begin
            if (s_q.op == nfs_pkg::OP_SUSPEND) s_d.susp = 1'b1;
            if (s_q.op == nfs_pkg::OP_RESUME) begin
               s_d.susp = 1'b0;
               s_d.gap  = 24'(GAP_CYC);                                    // see R14
            end
            s_d.done    = 1'b1;
            s_d.bus_rdy = 1'b1;
            s_d.st      = nfs_pkg::ST_IDLE;
         end
         default: s_d.st = nfs_pkg::ST_IDLE;
      endcase
      if (s_q.st == nfs_pkg::ST_WHIGH && s_q.op == nfs_pkg::OP_BUF_PROG &&
          s_q.step == 3'd3 && s_q.tcnt == 8'd0) s_d.step = 3'd5;
      if (!rst_n) begin
         s_d = '0;
         s_d.st  = nfs_pkg::ST_IDLE;
         s_d.bus = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_out: 16'h0000, dq_oe: 1'b0};
         s_d.rb_sync = 2'b11;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign cmd_ready      = s_q.bus_rdy;
   assign wr_ready       = s_q.wrdy;
   assign cmd_done       = s_q.done;
   assign cmd_refused    = s_q.refused;
   assign flash_busy     = s_q.busy;
   assign prog_suspended = s_q.susp;
   assign flash_addr     = s_q.addr;
   assign flash_dq_out   = s_q.bus.dq_out;
   assign flash_dq_oe    = s_q.bus.dq_oe;
   assign flash_ce_n     = s_q.bus.ce_n;
   assign flash_we_n     = s_q.bus.we_n;
   assign flash_oe_n     = s_q.bus.oe_n;
endmodule : nfs_host

// [inc/nfs_pkg.sv]
// package for the nor flash command sequencer host controller.
// assumes an asynchronous x16 nor flash driven by ce/we/oe strobes.
package nfs_pkg;
   // =====================================================================
   // command addresses and codes
   localparam logic [11:0] UNLOCK1_ADDR   = 12'h0555;
   localparam logic [11:0] UNLOCK2_ADDR   = 12'h02aa;
   localparam logic [15:0] UNLOCK1_DATA   = 16'h00aa;
   localparam logic [15:0] UNLOCK2_DATA   = 16'h0055;
   localparam logic [15:0] CMD_BUF_LOAD   = 16'h0025;
   localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
   localparam logic [15:0] CMD_SUSP_LEGACY = 16'h00b0;
   localparam logic [15:0] CMD_SUSP_PROG  = 16'h0051;
   localparam logic [15:0] CMD_RES_LEGACY = 16'h0030;
   localparam logic [15:0] CMD_RES_PROG   = 16'h0050;
   localparam logic [15:0] CMD_BLANK      = 16'h0033;
   localparam logic [11:0] BLANK_ADDR     = 12'h0555;
   localparam int          BUF_WORDS      = 256;
   localparam logic [15:0] MAX_COUNT      = 16'h00ff;
   // status bit positions
   localparam int ST_BUSY_BIT  = 7;
   localparam int ST_ERASE_BIT = 5;
   localparam int ST_PROG_BIT  = 4;
   localparam int ST_ABORT_BIT = 3;
   // =====================================================================
   // timing: strobe phases of a write cycle and suspend/resume delays
   localparam int CLK_MHZ         = 100;
   localparam int WE_LOW_NS       = 40;
   localparam int WE_HIGH_NS      = 30;
   localparam int WE_LOW_CYC      = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_HIGH_CYC     = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int RES_SUSP_GAP_NS = 100000;
   localparam int RES_SUSP_GAP_CYC = (RES_SUSP_GAP_NS / 1000) * CLK_MHZ;
   localparam int RESUME_PREP_NS  = 40000;
   localparam int RESUME_PREP_CYC = (RESUME_PREP_NS / 1000) * CLK_MHZ;

   typedef enum logic [2:0] {
      OP_BUF_PROG = 3'h0,
      OP_SUSPEND  = 3'h1,
      OP_RESUME   = 3'h2,
      OP_BLANK    = 3'h3,
      OP_CHIP_ER  = 3'h4,
      OP_SECT_ER  = 3'h5
   } nfs_op_t;

   // gray along idle->load->strobe->gap->next
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_WLOW  = 3'b011,
      ST_WHIGH = 3'b010,
      ST_DATA  = 3'b110,
      ST_DONE  = 3'b111
   } nfs_state_t;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [15:0] dq_out;
      logic        dq_oe;
   } nfs_bus_t;
endpackage : nfs_pkg

// [tb/nfs_host_sva.sv]
// checker on the nfs_host ports: write strobes and request refusals.
// assumes one clock domain; bound onto every nfs_host instance.
module nfs_host_sva #(
   parameter int ADDR_W = 26
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              cmd_valid,
   input wire logic              cmd_ready,
   input wire nfs_pkg::nfs_op_t  cmd_op,
   input wire logic [8:0]        cmd_words,
   input wire logic              cmd_refused,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [15:0]       flash_dq_out,
   input wire logic              flash_dq_oe,
   input wire logic              flash_ce_n,
   input wire logic              flash_we_n,
   input wire logic              flash_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = cmd_valid && cmd_ready;
   // =====================================================================
   // write cycle shape
   property p_we_sel; !flash_we_n |-> !flash_ce_n && flash_dq_oe; endproperty
   a_we_sel: assert property (p_we_sel) else $error("strobe without select");
   property p_no_read; flash_dq_oe |-> flash_oe_n; endproperty
   a_no_read: assert property (p_no_read) else $error("output enable while driving");
   property p_we_low; $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n; endproperty
   a_we_low: assert property (p_we_low) else $error("strobe low length");
   property p_we_high; $rose(flash_we_n) |-> flash_we_n [*4]; endproperty
   a_we_high: assert property (p_we_high) else $error("strobe high length");
   property p_hold;
      !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
   endproperty
   a_hold: assert property (p_hold) else $error("address or data moved in strobe");
   // =====================================================================
   // refusals answer one cycle after the take
   property p_zero; take && cmd_op == nfs_pkg::OP_BUF_PROG && cmd_words == 9'h000 |=> cmd_refused;
   endproperty
   a_zero: assert property (p_zero) else $error("empty program accepted");
   property p_big; take && cmd_op == nfs_pkg::OP_BUF_PROG && cmd_words > 9'h100 |=> cmd_refused;
   endproperty
   a_big: assert property (p_big) else $error("oversize program accepted");
   property p_resume; take && cmd_op == nfs_pkg::OP_RESUME |=> cmd_refused || !cmd_ready;
   endproperty
   a_resume: assert property (p_resume) else $error("resume answer missing");
endmodule : nfs_host_sva

bind nfs_host nfs_host_sva #(.ADDR_W(ADDR_W)) nfs_host_sva_inst (.clk, .rst_n, .cmd_valid,
   .cmd_ready, .cmd_op, .cmd_words, .cmd_refused, .flash_addr, .flash_dq_out, .flash_dq_oe,
   .flash_ce_n, .flash_we_n, .flash_oe_n);

// [tb/nfs_flash_model.sv]
// behavioural nor flash: logs every write cycle and plays ready/busy.
// assumes registered strobes from the host, sampled on clk.
module nfs_flash_model #(
   parameter int ADDR_W   = 26,
   parameter int BUSY_CYC = 300
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] flash_addr,
   input  wire logic [15:0]       flash_dq_out,
   input  wire logic              flash_ce_n,
   input  wire logic              flash_we_n,
   output logic                   ready_busy_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [ADDR_W-1:0] log_a [0:511];
   logic [15:0]       log_d [0:511];
   int                n, cnt;
   logic              we_q, susp, chip;
   logic [1:0]        setup;
   logic [15:0]       d;
   assign d = flash_dq_out;
   // a suspended job frees the pin and freezes its count
   assign ready_busy_n = !(cnt != 0 && !susp);
   always @(posedge clk) begin
      we_q <= flash_we_n;
      if (!rst_n) begin
         n <= 0;
         cnt <= 0;
         susp <= 1'b0;
         chip <= 1'b0;
         setup <= 2'd0;
      end else begin
         if (cnt != 0 && !susp) cnt <= cnt - 1;
         if (flash_we_n && !we_q && !flash_ce_n) begin
            log_a[n[8:0]] <= flash_addr;
            log_d[n[8:0]] <= d;
            n <= n + 1;
            if (cnt != 0) begin
               // chip erase drops suspends; repeated resumes fall through
               if (!susp && !chip && (d == 16'h0051 || d == 16'h00b0)) begin
                  susp <= 1'b1;
               end else if (susp && (d == 16'h0050 || d == 16'h0030)) begin
                  susp <= 1'b0;
               end
            end else if (setup != 2'd0) begin
               // two unlocks after the setup, busy only on the sixth write
               if (setup == 2'd3) begin
                  cnt <= BUSY_CYC;
                  chip <= (d == 16'h0010);
                  setup <= 2'd0;
               end else begin
                  setup <= setup + 2'd1;
               end
            end else if (d == 16'h0080) begin
               setup <= 2'd1;
            end else if (d == 16'h0029 || d == 16'h0033) begin
               cnt <= BUSY_CYC;
               chip <= 1'b0;
            end
         end
      end
   end
endmodule : nfs_flash_model

// [tb/nfs_host_test.sv]
// bench for nfs_host facing the behavioural flash model.
// assumes a 100 MHz clk and synchronous active-low reset.
module nfs_host_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AW = 26;
   localparam logic [AW-1:0] LOW = 26'h000_0fff;
   localparam logic [AW-1:0] SEC = 26'h3ff_0000;
   localparam logic [15:0] ED [0:4] = '{16'h00aa, 16'h0055, 16'h0080, 16'h00aa, 16'h0055};
   logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0;
   logic cmd_ready, wr_ready, cmd_done, cmd_refused, flash_busy, prog_suspended;
   logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, ready_busy_n;
   nfs_pkg::nfs_op_t cmd_op = nfs_pkg::OP_BUF_PROG;
   logic [AW-1:0]    cmd_addr = '0, flash_addr;
   logic [8:0]       cmd_words = '0;
   logic [15:0]      wr_data, flash_dq_out;
   int               miscompares = 0, comparisons = 0, n0, widx = 0;
   always #5 clk = ~clk;
   assign wr_data = 16'h1200 + 16'(widx);
   always @(posedge clk) if (wr_valid === 1'b1 && wr_ready === 1'b1) #1 widx = widx + 1;
   nfs_host #(.GAP_CYC(20)) nfs_host_inst (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr,
      .cmd_words, .cmd_ready, .wr_valid, .wr_data, .wr_ready, .cmd_done, .cmd_refused,
      .flash_busy, .prog_suspended, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
      .flash_we_n, .flash_oe_n, .ready_busy_n);
   nfs_flash_model nfs_flash_model_inst (.clk, .rst_n, .flash_addr, .flash_dq_out,
      .flash_ce_n, .flash_we_n, .ready_busy_n);
   // =====================================================================
   // shared tasks
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic stop(input logic ok);
      if (ok !== 1'b1) begin
         check(32'h0000_0000, 32'h0000_0001);
         summarize();
      end
   endtask : stop
   task automatic cw(input int k, input logic [AW-1:0] m, a, input logic [15:0] d);
      check(32'(nfs_flash_model_inst.log_a[n0 + k] & m), 32'(a & m));
      check(32'(nfs_flash_model_inst.log_d[n0 + k]), 32'(d));
   endtask : cw
   task automatic wait_busy(input logic v);
      for (int i = 0; i < 1000 && flash_busy !== v; i++) @(posedge clk);
      stop(flash_busy === v);
   endtask : wait_busy
   task automatic issue(input nfs_pkg::nfs_op_t op, input logic [AW-1:0] a,
                        input logic [8:0] n, input logic refuse);
      int i;
      @(posedge clk);
      #1;
      n0 = nfs_flash_model_inst.n;
      widx = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_words = n;
      cmd_valid = 1'b1;
      wr_valid = (op == nfs_pkg::OP_BUF_PROG);
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (cmd_ready !== 1'b1 && i < 50);
      stop(cmd_ready === 1'b1);
      #1 cmd_valid = 1'b0;
      i = 0;
      // a refusal already stands here, one cycle after the take
      while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && i < 4000) begin
         @(posedge clk);
         #1 i++;
      end
      stop(cmd_done === 1'b1 || cmd_refused === 1'b1);
      check(32'(cmd_refused), 32'(refuse));
      wr_valid = 1'b0;
   endtask : issue
   // =====================================================================
   // scenarios
   task automatic t_prog(input logic [AW-1:0] sa, input logic [8:0] n);
      issue(nfs_pkg::OP_BUF_PROG, sa, n, 1'b0);
      cw(0, LOW, 26'h555, 16'h00aa);
      cw(1, LOW, 26'h2aa, 16'h0055);
      cw(2, SEC, sa, 16'h0025);
      cw(3, SEC, sa, 16'(n - 1));
      for (int k = 0; k < n; k++) cw(4 + k, '1, sa + AW'(k), 16'h1200 + 16'(k));
      cw(4 + n, SEC, sa, 16'h0029);
      wait_busy(1'b1);
   endtask : t_prog
   task automatic t_susp();
      issue(nfs_pkg::OP_SUSPEND, '0, 9'h0, 1'b0);
      cw(0, '0, '0, 16'h0051);
      check(32'(prog_suspended), 32'h1);
      wait_busy(1'b0);
      issue(nfs_pkg::OP_SUSPEND, '0, 9'h0, 1'b1);
      issue(nfs_pkg::OP_BLANK, '0, 9'h0, 1'b1);
      issue(nfs_pkg::OP_RESUME, '0, 9'h0, 1'b0);
      cw(0, '0, '0, 16'h0050);
      issue(nfs_pkg::OP_SUSPEND, '0, 9'h0, 1'b1);
      repeat (30) @(posedge clk);
      issue(nfs_pkg::OP_SUSPEND, '0, 9'h0, 1'b0);
      issue(nfs_pkg::OP_RESUME, '0, 9'h0, 1'b0);
      issue(nfs_pkg::OP_RESUME, '0, 9'h0, 1'b1);
      check(32'(prog_suspended), 32'h0);
      wait_busy(1'b0);
   endtask : t_susp
   task automatic t_refuse();
      issue(nfs_pkg::OP_BUF_PROG, 26'h2a_3000, 9'h000, 1'b1);
      issue(nfs_pkg::OP_BUF_PROG, 26'h2a_3000, 9'h101, 1'b1);
      issue(nfs_pkg::OP_BUF_PROG, 26'h2a_30fe, 9'h003, 1'b1);
      check(32'(nfs_flash_model_inst.n), 32'(n0));
   endtask : t_refuse
   task automatic t_erase(input logic [AW-1:0] sa);
      for (int e = 0; e < 2; e++) begin
         issue(e ? nfs_pkg::OP_SECT_ER : nfs_pkg::OP_CHIP_ER, sa, 9'h000, 1'b0);
         for (int k = 0; k < 5; k++) cw(k, (k == 2) ? 26'h0 : LOW, (k % 3 == 1) ? 26'h2aa : 26'h555,
                                        ED[k]);
         cw(5, SEC, sa, e ? 16'h0030 : 16'h0010);
         wait_busy(1'b1);
         issue(nfs_pkg::OP_BLANK, sa, 9'h000, 1'b1);
         wait_busy(1'b0);
      end
      issue(nfs_pkg::OP_BLANK, sa, 9'h000, 1'b0);
      cw(0, SEC | LOW, (sa & SEC) | 26'h555, 16'h0033);
      wait_busy(1'b1);
      wait_busy(1'b0);
   endtask : t_erase
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      t_prog(26'h2a_30fd, 9'h003);
      t_susp();
      t_refuse();
      t_prog(26'h2b_0000, 9'h100);
      wait_busy(1'b0);
      t_erase(26'h15_4321);
      summarize();
   end
endmodule : nfs_host_test
